// ==== hdl/cpu_status_pkg.sv ====
// Constants and types shared by the status and bank select logic
package cpu_status_pkg;
    localparam int          ADDR_W        = 9;
    localparam int          FILE_W        = 7;
    localparam int          HOLD_W        = 5;
    localparam int          BANK_SIZE     = 128;
    // Low seven address bits; the register answers in every bank
    localparam logic [6:0]  STATUS_LOW7   = 7'h03;
    localparam logic [6:0]  HOLD_LOW7     = 7'h0a;
    localparam logic [8:0]  STATUS_OFFSET = 9'h003;
    localparam logic [8:0]  HOLD_OFFSET   = 9'h18a;
    // Unimplemented low addresses in banks 2 and 3
    localparam logic [6:0]  UNIMP_A       = 7'h05;
    localparam logic [6:0]  UNIMP_B       = 7'h07;
    localparam logic [6:0]  UNIMP_C       = 7'h08;
    localparam logic [6:0]  UNIMP_D       = 7'h09;
    localparam int          HIGH_BANK_BIT = 8;
    // Status field positions
    localparam int          IND_BANK_BIT  = 7;
    localparam int          DIR_HIGH_BIT  = 6;
    localparam int          DIR_LOW_BIT   = 5;
    localparam int          EXPIRY_BIT    = 4;
    localparam int          PDOWN_BIT     = 3;
    localparam int          ZERO_BIT      = 2;
    localparam int          HALF_BIT      = 1;
    localparam int          CARRY_BIT     = 0;
    localparam int          NIBBLE_W      = 4;
    localparam logic [7:0]  STATUS_RESET  = 8'h18;
    localparam logic [4:0]  HOLD_RESET    = 5'h00;
    localparam logic [2:0]  AFFECT_ARITH  = 3'h7;
    localparam logic [2:0]  AFFECT_ZERO   = 3'h4;
    localparam logic [2:0]  AFFECT_CARRY  = 3'h1;
    localparam logic [2:0]  AFFECT_NONE   = 3'h0;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_PASS_ZERO,
        OP_CLEAR,
        OP_ADD,
        OP_SUB,
        OP_ROT_LEFT,
        OP_ROT_RIGHT
    } alu_op_t;
endpackage

// ==== hdl/flag_calc_if.sv ====
// Carrier between the status register and its flag calculator
`timescale 1ns/1ps
`default_nettype none
interface flag_calc_if;
    cpu_status_pkg::alu_op_t op;
    logic [7:0]              a;
    logic [7:0]              b;
    logic                    carry_in;
    logic [7:0]              result;
    logic [2:0]              flags;
    logic [2:0]              affects;

    modport calc (
        input  op,
        input  a,
        input  b,
        input  carry_in,
        output result,
        output flags,
        output affects
    );
    modport user (
        output op,
        output a,
        output b,
        output carry_in,
        input  result,
        input  flags,
        input  affects
    );
endinterface
`default_nettype wire

// ==== hdl/status_flag_calc.sv ====
// Result and zero, half carry and carry flags of one instruction
`timescale 1ns/1ps
`default_nettype none
module status_flag_calc (
    flag_calc_if.calc fc
);
    wire       is_sub = (fc.op == cpu_status_pkg::OP_SUB);
    // Subtract adds the complement plus one, so carry means no borrow
    wire [7:0] a_eff  = is_sub ? ~fc.a : fc.a;
    wire [8:0] sum    = {1'b0, fc.b} + {1'b0, a_eff} + {8'h00, is_sub};
    wire [4:0] nibble = {1'b0, fc.b[3:0]} + {1'b0, a_eff[3:0]}
                        + {4'h0, is_sub};
    wire       arith  = (fc.op == cpu_status_pkg::OP_ADD) || is_sub;
    wire       rot_l  = (fc.op == cpu_status_pkg::OP_ROT_LEFT);
    wire       rot_r  = (fc.op == cpu_status_pkg::OP_ROT_RIGHT);
    wire       clr    = (fc.op == cpu_status_pkg::OP_CLEAR);
    wire       zone   = clr || (fc.op == cpu_status_pkg::OP_PASS_ZERO);

    wire [7:0] res_rl = {fc.b[6:0], fc.carry_in};
    wire [7:0] res_rr = {fc.carry_in, fc.b[7:1]};
    wire [7:0] result = arith ? sum[7:0] :
                        rot_l ? res_rl :
                        rot_r ? res_rr :
                        clr   ? 8'h00 : fc.b;
    // Shifted-out bit becomes the carry on rotates
    wire       c_rot  = rot_l ? fc.b[7] : fc.b[0];
    wire       c_new  = arith ? sum[8] : c_rot;
    wire       dc_new = nibble[cpu_status_pkg::NIBBLE_W];
    wire       z_new  = (result == 8'h00);

    assign fc.result  = result;
    assign fc.flags   = {z_new, dc_new, c_new};
    assign fc.affects = arith          ? cpu_status_pkg::AFFECT_ARITH :
                        zone           ? cpu_status_pkg::AFFECT_ZERO  :
                        (rot_l || rot_r) ? cpu_status_pkg::AFFECT_CARRY :
                        cpu_status_pkg::AFFECT_NONE;
endmodule
`default_nettype wire

// ==== hdl/cpu_status_bank_select.sv ====
// Core status register, bank selection and program counter holding register
`timescale 1ns/1ps
`default_nettype none
module cpu_status_bank_select (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       exec_in,
    input  wire logic [2:0] alu_op_in,
    input  wire logic [7:0] operand_a_in,
    input  wire logic [7:0] operand_b_in,
    input  wire logic       dest_we_in,
    input  wire logic [8:0] dest_addr_in,
    input  wire logic [8:0] rd_addr_in,
    input  wire logic [6:0] file_field_in,
    input  wire logic [7:0] pointer_in,
    input  wire logic       pc_high_load_in,
    input  wire logic       wdt_kick_in,
    input  wire logic       sleep_in,
    input  wire logic       wdt_timeout_in,
    output logic      [7:0] rd_data_out,
    output logic            rd_claim_out,
    output logic      [7:0] result_out,
    output logic      [7:0] status_out,
    output logic      [4:0] pc_high_out,
    output logic      [8:0] direct_addr_out,
    output logic      [8:0] indirect_addr_out
);
    localparam int ZB = cpu_status_pkg::ZERO_BIT;
    localparam int HB = cpu_status_pkg::HALF_BIT;
    localparam int CB = cpu_status_pkg::CARRY_BIT;
    localparam int TB = cpu_status_pkg::EXPIRY_BIT;
    localparam int PB = cpu_status_pkg::PDOWN_BIT;
    localparam int IB = cpu_status_pkg::IND_BANK_BIT;
    localparam int DH = cpu_status_pkg::DIR_HIGH_BIT;
    localparam int DL = cpu_status_pkg::DIR_LOW_BIT;

    // Only the low seven bits decide: the register is common to all banks
    function automatic logic is_status(input logic [8:0] addr);
        is_status = (addr[6:0] == cpu_status_pkg::STATUS_LOW7);
    endfunction

    function automatic logic is_holding(input logic [8:0] addr);
        is_holding = (addr[6:0] == cpu_status_pkg::HOLD_LOW7);
    endfunction

    function automatic logic is_unimpl(input logic [8:0] addr);
        logic [6:0] low;
        low = addr[6:0];
        is_unimpl = addr[cpu_status_pkg::HIGH_BANK_BIT]
                    && (low == cpu_status_pkg::UNIMP_A
                        || low == cpu_status_pkg::UNIMP_B
                        || low == cpu_status_pkg::UNIMP_C
                        || low == cpu_status_pkg::UNIMP_D);
    endfunction

    logic [7:0] status;
    logic [4:0] holding;
    logic [7:0] next_status;

    flag_calc_if fc ();

    status_flag_calc flag_calc (
        .fc (fc.calc)
    );

    assign fc.op       = cpu_status_pkg::alu_op_t'(alu_op_in);
    assign fc.a        = operand_a_in;
    assign fc.b        = operand_b_in;
    assign fc.carry_in = status[CB];

    wire [7:0] result    = fc.result;
    wire [2:0] calc_flag = fc.flags;
    wire       dest_wr   = exec_in && dest_we_in;
    // Status is an ordinary destination; bank bits take the result
    wire       status_wr = dest_wr && is_status(dest_addr_in);
    wire       hold_wr   = dest_wr && is_holding(dest_addr_in);
    wire [2:0] affects   = exec_in ? fc.affects : 3'h0;
    wire [2:0] bank_next = status_wr ? result[IB:DL] : status[IB:DL];

    // Set sources win over a time-out in the same cycle
    wire to_set   = wdt_kick_in || sleep_in;
    wire next_to  = to_set ? 1'b1 : (wdt_timeout_in ? 1'b0 : status[TB]);
    wire next_pd  = wdt_kick_in ? 1'b1 : (sleep_in ? 1'b0 : status[PB]);

    // Any flag-affecting op shuts the byte out of all three flags
    wire       low_wr    = status_wr && (affects == cpu_status_pkg::AFFECT_NONE);
    genvar gi;
    generate
        for (gi = 0; gi <= ZB; gi++) begin : g_flag
            assign next_status[gi] = affects[gi] ? calc_flag[gi] :
                                     low_wr ? result[gi] : status[gi];
        end
    endgenerate

    // Expiry and power-down never take the written byte
    assign next_status[TB]    = next_to;
    assign next_status[PB]    = next_pd;
    assign next_status[IB:DL] = bank_next;

    wire [7:0] rd_mux = is_status(rd_addr_in)  ? status :
                        is_holding(rd_addr_in) ? {3'h0, holding} :
                        8'h00;
    wire       claim  = is_status(rd_addr_in) || is_holding(rd_addr_in)
                        || is_unimpl(rd_addr_in);

    // Direct: two bank bits above the seven-bit field; 128 bytes per bank
    wire [8:0] dir_addr = {status[DH], status[DL], file_field_in};
    // Indirect: one bank bit above the eight-bit pointer
    wire [8:0] ind_addr = {status[IB], pointer_in};

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            status  <= cpu_status_pkg::STATUS_RESET;
            holding <= cpu_status_pkg::HOLD_RESET;
        end else begin
            status <= next_status;
            if (hold_wr) begin
                holding <= result[4:0];
            end
        end
    end

    // Counter upper bits are only ever loaded from the holding register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pc_high_out <= cpu_status_pkg::HOLD_RESET;
        end else if (pc_high_load_in) begin
            pc_high_out <= holding;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_data_out       <= 8'h00;
            rd_claim_out      <= 1'b0;
            result_out        <= 8'h00;
            direct_addr_out   <= 9'h000;
            indirect_addr_out <= 9'h000;
        end else begin
            rd_data_out       <= rd_mux;
            rd_claim_out      <= claim;
            result_out        <= result;
            direct_addr_out   <= dir_addr;
            indirect_addr_out <= ind_addr;
        end
    end

    assign status_out = status;

    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    wire op_none  = (alu_op_in == 3'(cpu_status_pkg::OP_NONE));
    wire op_clear = (alu_op_in == 3'(cpu_status_pkg::OP_CLEAR));
    wire op_add   = (alu_op_in == 3'(cpu_status_pkg::OP_ADD));
    wire op_sub   = (alu_op_in == 3'(cpu_status_pkg::OP_SUB));
    wire op_rotl  = (alu_op_in == 3'(cpu_status_pkg::OP_ROT_LEFT));
    wire op_rotr  = (alu_op_in == 3'(cpu_status_pkg::OP_ROT_RIGHT));
    wire no_rst_src = !wdt_kick_in && !sleep_in && !wdt_timeout_in;
    wire [8:0] ref_sum = {1'b0, operand_a_in} + {1'b0, operand_b_in};
    wire [4:0] ref_nib = {1'b0, operand_a_in[3:0]}
                         + {1'b0, operand_b_in[3:0]};

    sequence plain_status_write;
        exec_in && dest_we_in && is_status(dest_addr_in) && op_none;
    endsequence

    sequence clear_status;
        exec_in && dest_we_in && is_status(dest_addr_in) && op_clear;
    endsequence

    sequence holding_written;
        exec_in && dest_we_in && is_holding(dest_addr_in) && op_none;
    endsequence

    sequence rotate_to_status;
        exec_in && dest_we_in && is_status(dest_addr_in) && (op_rotl || op_rotr);
    endsequence

    status_mirror_a: assert property (
        plain_status_write |=> status_out == {$past(operand_b_in[7:5]),
            $past(status_out[4:3]), $past(operand_b_in[2:0])}
        || !$past(no_rst_src))
        else $error("status write not taken at banked address");

    holding_path_a: assert property (
        holding_written ##1 !dest_we_in ##1 (!dest_we_in && pc_high_load_in)
        |=> pc_high_out == $past(operand_b_in[4:0], 3))
        else $error("counter high bits not from holding register");

    common_read_a: assert property (
        is_holding(rd_addr_in) |=> rd_data_out == {3'h0, $past(holding)}
        && rd_claim_out)
        else $error("holding register read differs across banks");

    unimpl_zero_a: assert property (
        is_unimpl(rd_addr_in) |=> rd_data_out == 8'h00 && rd_claim_out)
        else $error("unimplemented location read nonzero");

    flag_override_a: assert property (
        (exec_in && dest_we_in && is_status(dest_addr_in) && op_add)
        |=> status_out[2:0] == $past(calc_flag))
        else $error("written byte leaked into arithmetic flags");

    ro_flags_a: assert property (
        no_rst_src |=> $stable(status_out[4:3]))
        else $error("expiry or power-down flag changed by write");

    clear_status_a: assert property (
        clear_status ##0 no_rst_src |=> status_out[7:5] == 3'h0
        && status_out[ZB] && status_out[4:3] == $past(status_out[4:3])
        && status_out[1:0] == $past(status_out[1:0]))
        else $error("clear of status gave wrong pattern");

    sub_borrow_a: assert property (
        (exec_in && op_sub) |=> status_out[CB]
        == ($past(operand_b_in) >= $past(operand_a_in)))
        else $error("subtract carry is not inverted borrow");

    add_carry_a: assert property (
        (exec_in && op_add) |=> status_out[CB] == $past(ref_sum[8])
        && status_out[HB] == $past(ref_nib[4]))
        else $error("add carry or half carry wrong");

    rotate_carry_a: assert property (
        (exec_in && (op_rotl || op_rotr)) |=> status_out[CB]
        == ($past(op_rotl) ? $past(operand_b_in[7])
                           : $past(operand_b_in[0])))
        else $error("rotate did not load shifted-out bit");

    indirect_bank_a: assert property (
        1'b1 |=> indirect_addr_out
        == {$past(status_out[IB]), $past(pointer_in)})
        else $error("indirect address bank wrong");

    direct_bank_a: assert property (
        1'b1 |=> direct_addr_out / cpu_status_pkg::BANK_SIZE
        == $past(status_out[DH:DL])
        && direct_addr_out[6:0] == $past(file_field_in))
        else $error("direct address bank or offset wrong");

    expiry_flag_a: assert property (
        (wdt_kick_in || sleep_in) |=> status_out[TB] ##1
        (!$past(wdt_timeout_in) || $past(wdt_kick_in || sleep_in)
         || !status_out[TB]))
        else $error("expiry flag set or clear missed");

    timeout_clear_a: assert property (
        (wdt_timeout_in && !wdt_kick_in && !sleep_in)
        |=> !status_out[TB])
        else $error("time-out did not clear expiry flag");

    sleep_pd_a: assert property (
        (sleep_in && !wdt_kick_in) |=> !status_out[PB] && status_out[TB])
        else $error("sleep did not clear power-down flag");

    kick_pd_a: assert property (
        wdt_kick_in |=> status_out[PB] && status_out[TB])
        else $error("kick did not set expiry and power-down flags");

    sub_half_a: assert property (
        (exec_in && op_sub) |=> status_out[HB]
        == ($past(operand_b_in[3:0]) >= $past(operand_a_in[3:0])))
        else $error("subtract half carry is not inverted digit borrow");

    rotate_keep_a: assert property (
        rotate_to_status |=> status_out[ZB:HB] == $past(status_out[ZB:HB])
        && status_out[IB:DL] == $past(operand_b_in[6:4]))
        else $error("rotate into status leaked byte into zero or half carry");

    add_zero_a: assert property (
        (exec_in && op_add) |=> status_out[ZB] == ($past(ref_sum[7:0]) == 8'h00))
        else $error("add zero flag wrong");

    add_result_a: assert property (
        (exec_in && op_add) |=> result_out == $past(ref_sum[7:0]))
        else $error("add result wrong");

    pc_hold_a: assert property (
        !pc_high_load_in |=> $stable(pc_high_out))
        else $error("counter high bits moved without a load");

    no_claim_a: assert property (
        !(is_status(rd_addr_in) || is_holding(rd_addr_in) || is_unimpl(rd_addr_in))
        |=> rd_data_out == 8'h00 && !rd_claim_out)
        else $error("foreign address read nonzero or claimed");
endmodule
`default_nettype wire

// ==== tb/core_exec_model.sv ====
// Behavioural model of the core execution and reset logic feeding the status block
`timescale 1ns/1ps
`default_nettype none
module core_exec_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rd_data_in,
    input  wire logic       rd_claim_in,
    input  wire logic [7:0] result_in,
    output logic            exec_out,
    output logic      [2:0] alu_op_out,
    output logic      [7:0] operand_a_out,
    output logic      [7:0] operand_b_out,
    output logic            dest_we_out,
    output logic      [8:0] dest_addr_out,
    output logic      [8:0] rd_addr_out,
    output logic      [6:0] file_field_out,
    output logic      [7:0] pointer_out,
    output logic            pc_high_load_out,
    output logic            wdt_kick_out,
    output logic            sleep_out,
    output logic            wdt_timeout_out
);
    logic [7:0] last_result;

    initial begin
        {exec_out, alu_op_out, operand_a_out, operand_b_out} = 20'h0_0000;
        {dest_we_out, dest_addr_out, rd_addr_out} = 19'h0_0000;
        {file_field_out, pointer_out} = 15'h0000;
        {pc_high_load_out, wdt_kick_out, sleep_out, wdt_timeout_out} = 4'h0;
    end

    // Moves, bit set/clear and swaps arrive as ready bytes with the no-flag op
    task automatic exec_op(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
                           input logic we, input logic [8:0] addr);
        alu_op_out = op;
        operand_a_out = a;
        operand_b_out = b;
        dest_we_out = we;
        dest_addr_out = addr;
        exec_out = 1'b1;
        @(posedge clk_in);
        #1;
        // Only a rotate result changes next cycle; it refills from the new carry after
        last_result = result_in;
        exec_out = 1'b0;
        dest_we_out = 1'b0;
        // Idle edge so a following call never reasserts in the same step
        @(posedge clk_in);
        #1;
    endtask

    task automatic strobe(input logic kick, input logic slp, input logic tmo, input logic load);
        {wdt_kick_out, sleep_out, wdt_timeout_out, pc_high_load_out} = {kick, slp, tmo, load};
        @(posedge clk_in);
        #1;
        {wdt_kick_out, sleep_out, wdt_timeout_out, pc_high_load_out} = 4'h0;
        @(posedge clk_in);
        #1;
    endtask

    task automatic set_ptrs(input logic [6:0] ff, input logic [7:0] ptr);
        file_field_out = ff;
        pointer_out = ptr;
    endtask

    task automatic read_reg(input logic [8:0] addr, output logic [7:0] d, output logic c);
        rd_addr_out = addr;
        @(posedge clk_in);
        #1;
        d = rd_data_in;
        c = rd_claim_in;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_cpu_status_bank_select.sv ====
// Self-checking bench for the status, bank select and holding register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
end
module tb_cpu_status_bank_select;
    logic       clk_in;
    logic       rst_n_in;
    logic       exec, dest_we, pc_load, kick, slp, tmo, rd_claim;
    logic [2:0] alu_op;
    logic [7:0] op_a, op_b, ptr, rd_data, result, status;
    logic [8:0] dest_addr, rd_addr, dir_addr, ind_addr;
    logic [6:0] ff;
    logic [4:0] pc_high;
    int         num_errors = 0;
    int         n_compared = 0;
    logic [2:0] t_op [8];
    logic [7:0] t_a [8];
    logic [7:0] t_b [8];
    logic [7:0] t_res [8];
    logic [2:0] t_flg [8];
    logic [8:0] unimp [5];

    cpu_status_bank_select u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .exec_in(exec), .alu_op_in(alu_op),
        .operand_a_in(op_a), .operand_b_in(op_b), .dest_we_in(dest_we),
        .dest_addr_in(dest_addr), .rd_addr_in(rd_addr), .file_field_in(ff),
        .pointer_in(ptr), .pc_high_load_in(pc_load), .wdt_kick_in(kick), .sleep_in(slp),
        .wdt_timeout_in(tmo), .rd_data_out(rd_data), .rd_claim_out(rd_claim),
        .result_out(result), .status_out(status), .pc_high_out(pc_high),
        .direct_addr_out(dir_addr), .indirect_addr_out(ind_addr)
    );
    core_exec_model u_core (
        .clk_in(clk_in), .rd_data_in(rd_data), .rd_claim_in(rd_claim), .result_in(result),
        .exec_out(exec), .alu_op_out(alu_op), .operand_a_out(op_a), .operand_b_out(op_b),
        .dest_we_out(dest_we), .dest_addr_out(dest_addr), .rd_addr_out(rd_addr),
        .file_field_out(ff), .pointer_out(ptr), .pc_high_load_out(pc_load),
        .wdt_kick_out(kick), .sleep_out(slp), .wdt_timeout_out(tmo)
    );

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task automatic summarize();
        $display("Mismatches %0d in %0d compares", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check_rd(input logic [8:0] addr, input logic [7:0] ed, input logic ec);
        logic [7:0] d;
        logic       c;
        u_core.read_reg(addr, d, c);
        `CHK("read data", ed, d)
        `CHK("read claim", ec, c)
    endtask

    // Whole run is about 65 cycles; this only cuts a hang short
    initial begin
        #2_000_000;
        num_errors++;
        summarize();
    end

    initial begin
        t_op = '{cpu_status_pkg::OP_ADD, cpu_status_pkg::OP_ADD, cpu_status_pkg::OP_SUB,
                 cpu_status_pkg::OP_SUB, cpu_status_pkg::OP_SUB, cpu_status_pkg::OP_ROT_LEFT,
                 cpu_status_pkg::OP_ROT_RIGHT, cpu_status_pkg::OP_ROT_RIGHT};
        t_a   = '{8'h0f, 8'h80, 8'h03, 8'h05, 8'h07, 8'h00, 8'h00, 8'h00};
        t_b   = '{8'h01, 8'h80, 8'h05, 8'h03, 8'h07, 8'h80, 8'h02, 8'h01};
        t_res = '{8'h10, 8'h00, 8'h02, 8'hfe, 8'h00, 8'h01, 8'h81, 8'h00};
        t_flg = '{3'h2, 3'h5, 3'h3, 3'h0, 3'h7, 3'h7, 3'h6, 3'h7};
        unimp = '{9'h105, 9'h107, 9'h185, 9'h188, 9'h189};
        rst_n_in = 1'b0;
        repeat (8) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        `CHK("status reset", 8'h18, status)
        `CHK("pc high reset", 5'h00, pc_high)
        check_rd(9'h18a, 8'h00, 1'b1);
        u_core.set_ptrs(7'h12, 8'h34);
        // Every bank code, indirect bit taken from the low bank bit
        for (int k = 0; k < 4; k++) begin
            u_core.exec_op(3'h0, 8'h00, {k[0], k[1:0], 5'h00}, 1'b1, 9'h003);
            `CHK("bank status", {k[0], k[1:0], 5'h18}, status)
            `CHK("direct addr", {k[1:0], 7'h12}, dir_addr)
            `CHK("indirect addr", {k[0], 8'h34}, ind_addr)
        end
        u_core.exec_op(3'h0, 8'h00, 8'he5, 1'b1, 9'h083);
        `CHK("move to status", 8'hfd, status)
        for (int k = 0; k < 4; k++) check_rd({k[1:0], 7'h03}, 8'hfd, 1'b1);
        u_core.exec_op(cpu_status_pkg::OP_CLEAR, 8'h00, 8'haa, 1'b1, 9'h103);
        `CHK("clear status", 8'h1d, status)
        `CHK("direct after clear", 9'h012, dir_addr)
        for (int i = 0; i < 8; i++) begin
            u_core.exec_op(t_op[i], t_a[i], t_b[i], 1'b0, 9'h020);
            `CHK("alu result", t_res[i], u_core.last_result)
            `CHK("alu flags", {5'h03, t_flg[i]}, status)
        end
        // Result byte would set carry; computed carry is clear
        u_core.exec_op(cpu_status_pkg::OP_ADD, 8'h21, 8'h00, 1'b1, 9'h003);
        `CHK("arith to status", 8'h38, status)
        // Rotate writes bank bits and carry; zero and half carry stay
        u_core.exec_op(cpu_status_pkg::OP_ROT_LEFT, 8'h00, 8'h9f, 1'b1, 9'h183);
        `CHK("rotate to status", 8'h39, status)
        u_core.strobe(1'b0, 1'b0, 1'b1, 1'b0);
        `CHK("after timeout", 2'b01, status[4:3])
        u_core.strobe(1'b0, 1'b1, 1'b0, 1'b0);
        `CHK("after sleep", 2'b10, status[4:3])
        u_core.strobe(1'b1, 1'b0, 1'b0, 1'b0);
        `CHK("after kick", 2'b11, status[4:3])
        u_core.exec_op(3'h0, 8'h00, 8'hff, 1'b1, 9'h00a);
        `CHK("pc high before load", 5'h00, pc_high)
        // Load right after the write so the holding path sequence is exercised
        u_core.strobe(1'b0, 1'b0, 1'b0, 1'b1);
        `CHK("pc high loaded", 5'h1f, pc_high)
        for (int k = 0; k < 4; k++) check_rd({k[1:0], 7'h0a}, 8'h1f, 1'b1);
        for (int i = 0; i < 5; i++) check_rd(unimp[i], 8'h00, 1'b1);
        check_rd(9'h020, 8'h00, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
